// File: design/spi_port_pkg.sv
// Package with the constants and carrier types of the tag's serial host port.
package spi_port_pkg;

   // ----------------------------------------------------------------------
   // Mode byte encodings
   // ----------------------------------------------------------------------
   localparam logic [2:0] MODE_REG_WR = 3'h0;
   localparam logic [2:0] MODE_REG_RD = 3'h1;
   localparam logic [2:0] MODE_EE_WR = 3'h2;
   localparam logic [2:0] MODE_EE_RD = 3'h3;
   localparam logic [2:0] MODE_BUF_LD = 3'h4;
   localparam logic [2:0] MODE_BUF_RD = 3'h5;
   localparam logic [1:0] MODE_CMD = 2'h3;

   // ----------------------------------------------------------------------
   // Widths, counts and answers
   // ----------------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int REG_AW = 5;
   localparam int BLK_AW = 7;
   localparam int CMD_W = 6;
   localparam int BLK_BYTES = 4;
   localparam int BUF_DEPTH = 16;
   localparam int BUF_MAX_LOAD = 32;
   localparam int NUM_REGS = 24;
   localparam int NUM_BLOCKS = 120;
   localparam logic [7:0] CMD_ACCEPTED = 8'h01;
   localparam logic [7:0] CMD_REJECTED = 8'h02;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [31:0] RO_MASK = 32'h00f0_0000;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int EE_PROG_US = 8300;
   localparam int EE_PROG_CYC = (EE_PROG_US / 1000) * (CLK_HZ / 1000)
                                + ((EE_PROG_US % 1000) * (CLK_HZ / 1000)) / 1000;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic ss_n;
      logic sclk;
      logic mosi;
   } spi_in_t;

   typedef struct packed {
      logic [BLK_AW-1:0] addr;
      logic [31:0] data;
   } ee_req_t;

endpackage

// File: design/byte_fifo.sv
// Parameterised first-word-fall-through FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

// File: design/ee_store.sv
// Small EEPROM block array with a registered read port.
`timescale 1ns/10ps
module ee_store #(
   parameter int BLOCKS = 120
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [6:0] rd_addr,
   output logic [31:0] rd_data_q
);
   logic [31:0] mem_q [BLOCKS];

   always_ff @(posedge clk) begin
      if (wr_en && (32'(wr_addr) < BLOCKS)) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Blocks past the array read as zero.
   always_ff @(posedge clk) begin
      if (32'(rd_addr) < BLOCKS) begin
         rd_data_q <= mem_q[rd_addr];
      end else begin
         rd_data_q <= '0;
      end
   end
endmodule

// File: design/nfc_host_port.sv
// Serial slave host port of a dynamic tag: registers, EEPROM, buffers, commands.
// How it works
// RL1 - Select falling starts; 3 mode bits; MSB first
// RL2 - Select high resets serial port state
// RL3 - Decode mode byte into the seven operations
// RL4 - Register write autoincrements address per byte
// RL5 - Commit byte at its eighth falling edge
// RL6 - Partial byte at select rise is dropped
// RL7 - Unmapped or read-only writes change nothing
// RL8 - Register read returns autoincremented bytes
// RL9 - Sample on falling, drive on rising edge
// RL10 - Unmapped register read returns zero
// RL11 - Block address in bits seven to one
// RL12 - Master sends exactly six bytes per block
// RL13 - Programming starts at select rising edge
// RL14 - Write-complete interrupt after programming time
// RL15 - EEPROM read streams four-byte autoincremented blocks
// RL16 - Missing block reads as zero
// RL17 - Master keeps clock slow on EEPROM reads
// RL18 - Buffer load puts bytes into transmit buffer
// RL19 - Buffer read returns receive buffer bytes
// RL20 - Partial buffer read byte still consumed
// RL21 - Direct command is 11 plus code
// RL22 - Argument byte answers accepted or rejected
// RL23 - EEPROM access first come first served
`timescale 1ns/10ps
module nfc_host_port #(
   parameter int EE_PROG_CYCLES = spi_port_pkg::EE_PROG_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ss_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe,
   output logic serial_out_pulldown_enable,
   output logic irq,
   output logic [7:0] tx_buf_data,
   output logic tx_buf_valid,
   input wire logic tx_buf_ready,
   input wire logic [7:0] rx_buf_data,
   input wire logic rx_buf_valid,
   output logic rx_buf_pop,
   output logic [5:0] cmd_code,
   output logic cmd_strobe,
   input wire logic cmd_busy,
   input wire logic rf_ee_req,
   output logic rf_ee_grant
);
   // ----------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------------
   spi_port_pkg::spi_in_t s1_q;
   spi_port_pkg::spi_in_t s2_q;
   logic sclk_prev_q;
   logic fall;
   logic rise;
   logic sel;

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_q <= 3'h4;
         s2_q <= 3'h4;
         sclk_prev_q <= 1'b0;
      end else begin
         s1_q <= '{ss_n: ss_n, sclk: sclk, mosi: mosi};
         s2_q <= s1_q;
         sclk_prev_q <= s2_q.sclk;
      end
   end

   assign sel = !s2_q.ss_n;
   assign fall = sel && sclk_prev_q && !s2_q.sclk; // RL9
   assign rise = sel && !sclk_prev_q && s2_q.sclk; // RL9

   logic ss_prev_q;
   logic ss_rise;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ss_prev_q <= 1'b1;
      end else begin
         ss_prev_q <= s2_q.ss_n;
      end
   end
   assign ss_rise = !ss_prev_q && s2_q.ss_n;

   // ----------------------------------------------------------------------
   // Transaction state
   // ----------------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_MODE = 7'h01,
      ST_REG = 7'h02,
      ST_EE_ADDR = 7'h04,
      ST_EE_WR = 7'h08,
      ST_EE_RD = 7'h10,
      ST_BUF = 7'h20,
      ST_CMD = 7'h40
   } state_t;

   state_t st_q;
   logic [2:0] mode_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [4:0] raddr_q;
   logic [6:0] baddr_q;
   logic [1:0] bidx_q;
   logic [2:0] ee_cnt_q;
   logic [31:0] ee_data_q;
   logic [5:0] load_cnt_q;

   assign rx_byte = {sh_q[6:0], s2_q.mosi};
   assign byte_done = fall && (bit_q == 3'h7);

   always_ff @(posedge mclk) begin
      if (rst || !sel) begin // RL2
         bit_q <= 3'h0;
         sh_q <= 8'h00;
      end else if (fall) begin
         sh_q <= rx_byte; // RL1
         bit_q <= bit_q + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || !sel) begin // RL2
         st_q <= ST_MODE;
         mode_q <= 3'h0;
         raddr_q <= 5'h00;
         baddr_q <= 7'h00;
         bidx_q <= 2'h0;
         ee_cnt_q <= 3'h0;
         ee_data_q <= 32'h0;
         load_cnt_q <= 6'h00;
      end else if (byte_done) begin
         unique case (st_q)
            ST_MODE: begin
               mode_q <= rx_byte[7:5]; // RL1
               raddr_q <= rx_byte[4:0];
               if (rx_byte[7:6] == spi_port_pkg::MODE_CMD) begin
                  st_q <= ST_CMD; // RL21
               end else if (rx_byte[7:5] == spi_port_pkg::MODE_REG_WR ||
                            rx_byte[7:5] == spi_port_pkg::MODE_REG_RD) begin
                  st_q <= ST_REG; // RL3
               end else if (rx_byte[7:5] == spi_port_pkg::MODE_EE_WR ||
                            rx_byte[7:5] == spi_port_pkg::MODE_EE_RD) begin
                  st_q <= ST_EE_ADDR;
               end else begin
                  st_q <= ST_BUF;
               end
            end
            ST_REG: begin
               raddr_q <= raddr_q + 5'h01; // RL4 RL8
            end
            ST_EE_ADDR: begin
               baddr_q <= rx_byte[7:1]; // RL11
               st_q <= (mode_q == spi_port_pkg::MODE_EE_WR) ? ST_EE_WR : ST_EE_RD;
            end
            ST_EE_WR: begin
               if (ee_cnt_q < 3'(spi_port_pkg::BLK_BYTES)) begin
                  ee_data_q <= {ee_data_q[23:0], rx_byte};
                  ee_cnt_q <= ee_cnt_q + 3'h1;
               end
            end
            ST_EE_RD: begin
               bidx_q <= bidx_q + 2'h1;
               if (bidx_q == 2'h3) begin
                  baddr_q <= baddr_q + 7'h01; // RL15
               end
            end
            ST_BUF: begin
               if (load_cnt_q != 6'(spi_port_pkg::BUF_MAX_LOAD)) begin
                  load_cnt_q <= load_cnt_q + 6'h01;
               end
            end
            ST_CMD: begin
               st_q <= ST_CMD;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   logic [7:0] regs_q [spi_port_pkg::NUM_REGS];

   function automatic logic reg_writable(input logic [4:0] a);
      reg_writable = (32'(a) < spi_port_pkg::NUM_REGS) && !spi_port_pkg::RO_MASK[a];
   endfunction

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < spi_port_pkg::NUM_REGS; i++) begin
            regs_q[i] <= spi_port_pkg::REG_RESET;
         end
      end else if (byte_done && st_q == ST_REG && mode_q == spi_port_pkg::MODE_REG_WR &&
                   reg_writable(raddr_q)) begin // RL5 RL6 RL7
         regs_q[raddr_q] <= rx_byte;
      end
   end

   assign serial_out_pulldown_enable = regs_q[0][0];

   // ----------------------------------------------------------------------
   // EEPROM programming, timing and arbitration
   // ----------------------------------------------------------------------
   logic ee_busy_q;
   logic [23:0] ee_tmr_q;
   logic ee_wr;
   logic rf_own_q;
   logic [31:0] ee_rd;
   logic ee_full;

   assign ee_full = ee_cnt_q == 3'(spi_port_pkg::BLK_BYTES);
   assign ee_wr = ss_rise && st_q == ST_EE_WR && ee_full && !rf_own_q; // RL13 RL23

   always_ff @(posedge mclk) begin
      if (rst) begin
         ee_busy_q <= 1'b0;
         ee_tmr_q <= 24'h0;
         irq <= 1'b0;
      end else begin
         irq <= 1'b0;
         if (ee_wr) begin
            ee_busy_q <= 1'b1;
            ee_tmr_q <= 24'(EE_PROG_CYCLES);
         end else if (ee_busy_q) begin
            ee_tmr_q <= ee_tmr_q - 24'h1;
            if (ee_tmr_q == 24'h1) begin
               ee_busy_q <= 1'b0;
               irq <= 1'b1; // RL14
            end
         end
      end
   end

   // The first side to ask holds the EEPROM until it lets go.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rf_own_q <= 1'b0;
         rf_ee_grant <= 1'b0;
      end else begin
         if (!rf_own_q && rf_ee_req && !ee_busy_q && !ee_wr &&
             !(sel && (st_q == ST_EE_RD || st_q == ST_EE_WR))) begin // RL23
            rf_own_q <= 1'b1;
         end else if (rf_own_q && !rf_ee_req) begin
            rf_own_q <= 1'b0;
         end
         rf_ee_grant <= rf_own_q && rf_ee_req;
      end
   end

   ee_store #(
      .BLOCKS(spi_port_pkg::NUM_BLOCKS)
   ) u_ee (
      .clk(mclk),
      .wr_en(ee_wr),
      .wr_addr(baddr_q),
      .wr_data(ee_data_q),
      .rd_addr(baddr_q),
      .rd_data_q(ee_rd) // RL16
   );

   // ----------------------------------------------------------------------
   // Transmit buffer
   // ----------------------------------------------------------------------
   logic load_push;
   logic load_ready;
   assign load_push = byte_done && st_q == ST_BUF && mode_q == spi_port_pkg::MODE_BUF_LD &&
                      load_cnt_q != 6'(spi_port_pkg::BUF_MAX_LOAD) && load_ready; // RL18

   logic [7:0] tx_d;
   logic tx_v;
   byte_fifo #(
      .WIDTH(spi_port_pkg::BYTE_W),
      .DEPTH(spi_port_pkg::BUF_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rst(rst),
      .in_valid(load_push),
      .in_ready(load_ready),
      .in_data(rx_byte),
      .out_valid(tx_v),
      .out_ready(tx_buf_ready && !tx_buf_valid),
      .out_data(tx_d)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_buf_valid <= 1'b0;
         tx_buf_data <= 8'h00;
      end else if (!tx_buf_valid || tx_buf_ready) begin
         tx_buf_valid <= tx_v && tx_buf_ready && !tx_buf_valid;
         tx_buf_data <= tx_d;
      end
   end

   // ----------------------------------------------------------------------
   // Readout shifter, buffer pop and direct command
   // ----------------------------------------------------------------------
   logic [7:0] out_sh_q;
   logic [7:0] next_byte;
   logic cmd_status_q;

   always_comb begin
      next_byte = 8'h00;
      unique case (st_q)
         ST_REG: begin
            if (mode_q == spi_port_pkg::MODE_REG_RD &&
                32'(raddr_q) < spi_port_pkg::NUM_REGS) begin // RL10
               next_byte = regs_q[raddr_q]; // RL8
            end
         end
         ST_EE_RD: next_byte = ee_rd[8*(3-bidx_q) +: 8]; // RL15 RL16
         ST_BUF: begin
            if (mode_q == spi_port_pkg::MODE_BUF_RD && rx_buf_valid) begin
               next_byte = rx_buf_data; // RL19
            end
         end
         ST_CMD: next_byte = cmd_status_q ? spi_port_pkg::CMD_REJECTED
                                          : spi_port_pkg::CMD_ACCEPTED; // RL22
         default: next_byte = 8'h00;
      endcase
   end

   logic reading;
   assign reading = st_q == ST_EE_RD || st_q == ST_CMD ||
                    (st_q == ST_REG && mode_q == spi_port_pkg::MODE_REG_RD) ||
                    (st_q == ST_BUF && mode_q == spi_port_pkg::MODE_BUF_RD);

   // A read byte is loaded at the rising edge that starts it; a bit count of zero marks that.
   always_ff @(posedge mclk) begin
      if (rst || !sel) begin // RL2
         out_sh_q <= 8'h00;
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
      end else if (rise) begin // RL9
         miso_oe <= reading;
         if (bit_q == 3'h0) begin
            out_sh_q <= {next_byte[6:0], 1'b0};
            miso_o <= next_byte[7];
         end else begin
            out_sh_q <= {out_sh_q[6:0], 1'b0};
            miso_o <= out_sh_q[7];
         end
      end
   end

   // The byte counts as read once its first bit left, even if select rises early.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_buf_pop <= 1'b0;
      end else begin
         rx_buf_pop <= rise && bit_q == 3'h0 && st_q == ST_BUF &&
                       mode_q == spi_port_pkg::MODE_BUF_RD && rx_buf_valid; // RL20
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_strobe <= 1'b0;
         cmd_code <= 6'h00;
         cmd_status_q <= 1'b0;
      end else begin
         cmd_strobe <= 1'b0;
         if (byte_done && st_q == ST_MODE && rx_byte[7:6] == spi_port_pkg::MODE_CMD) begin
            cmd_code <= rx_byte[5:0]; // RL21
            cmd_status_q <= cmd_busy || ee_busy_q;
            cmd_strobe <= !(cmd_busy || ee_busy_q);
         end
      end
   end

endmodule

// File: verif/nfc_host_port_checker.sv
// Concurrent checks on the ports of the serial host port.
`timescale 1ns/10ps
module nfc_host_port_checker #(
   parameter int EE_PROG_CYCLES = 50
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ss_n,
   input wire logic sclk,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic irq,
   input wire logic rx_buf_valid,
   input wire logic rx_buf_pop,
   input wire logic cmd_strobe,
   input wire logic cmd_busy,
   input wire logic rf_ee_req,
   input wire logic rf_ee_grant
);
   logic ss_q;
   logic [31:0] since_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Counts cycles since select last rose, so write-complete timing can be judged.
   always_ff @(posedge mclk) begin
      ss_q <= ss_n;
      if (rst || (ss_n && !ss_q)) begin
         since_q <= 32'h0;
      end else if (since_q != 32'hffff_ffff) begin
         since_q <= since_q + 32'h1;
      end
   end
   property p_oe_sel;
      miso_oe |-> !$past(ss_n, 6);
   endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("miso driven while deselected");
   property p_miso_hold;
      $fell(sclk) && miso_oe |-> ##2 $stable(miso_o) [*2];
   endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved in low phase");
   property p_irq_pulse;
      irq |=> !irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a pulse");
   property p_irq_late;
      irq |-> since_q >= 32'(EE_PROG_CYCLES);
   endproperty
   a_irq_late: assert property (p_irq_late) else $error("irq before programming time");
   property p_pop_pulse;
      rx_buf_pop |=> !rx_buf_pop;
   endproperty
   a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than a pulse");
   property p_pop_valid;
      rx_buf_pop |-> $past(rx_buf_valid);
   endproperty
   a_pop_valid: assert property (p_pop_valid) else $error("pop of empty buffer");
   property p_cmd_busy;
      cmd_strobe |-> !$past(cmd_busy);
   endproperty
   a_cmd_busy: assert property (p_cmd_busy) else $error("command taken while busy");
   property p_grant_req;
      rf_ee_grant |-> $past(rf_ee_req);
   endproperty
   a_grant_req: assert property (p_grant_req) else $error("grant without request");
   property p_grant_fast;
      $rose(rf_ee_req) && ss_n |-> ##[1:4] rf_ee_grant;
   endproperty
   a_grant_fast: assert property (p_grant_fast) else $error("idle grant too late");
endmodule

// File: verif/spi_master_model.sv
// Serial master model that plays the microcontroller side of the host port.
`timescale 1ns/10ps
module spi_master_model (
   input wire logic mclk,
   output logic ss_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   int half = 4;
   initial begin
      ss_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic start();
      @(posedge mclk);
      ss_n <= 1'b0;
      repeat (half) @(posedge mclk);
   endtask
   // Releasing select also inverts the data line so no stale bit lingers.
   task automatic stop();
      repeat (half) @(posedge mclk);
      ss_n <= 1'b1;
      mosi <= ~mosi;
      repeat (half) @(posedge mclk);
   endtask
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         @(posedge mclk);
         sclk <= 1'b1;
         mosi <= tx[i];
         repeat (half) @(posedge mclk);
         sclk <= 1'b0;
         @(negedge mclk);
         rx[i] = miso;
         repeat (half - 1) @(posedge mclk);
      end
   endtask
endmodule

// File: verif/tb_nfc_host_port.sv
// Self-checking testbench for the serial host port.
`timescale 1ns/10ps
module tb_nfc_host_port;
   localparam int P = 50;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ss_n, sclk, mosi, miso_pin, miso_o, miso_oe, serial_out_pulldown_enable, irq;
   logic tx_buf_valid, rx_buf_pop, cmd_strobe, rf_ee_grant, rx_buf_valid;
   logic [7:0] tx_buf_data, rx_buf_data;
   logic [5:0] cmd_code, last_code;
   logic tx_buf_ready = 1'b0;
   logic cmd_busy = 1'b0;
   logic rf_ee_req = 1'b0;
   logic idle_q = 1'b0;
   logic [3:0] rx_idx = 4'h0;
   logic [7:0] rx_mem [0:7];
   logic [7:0] rxb [0:9];
   logic [7:0] txq [$];
   int fail_count = 0;
   int checks = 0;
   int strobes = 0;
   assign rx_buf_data = rx_mem[rx_idx[2:0]];
   assign rx_buf_valid = !rx_idx[3];
   assign miso_pin = miso_oe ? miso_o : (serial_out_pulldown_enable ? 1'b0 : idle_q);
   initial forever #25 mclk = ~mclk;
   nfc_host_port #(.EE_PROG_CYCLES(P)) u_nfc_host_port (
      .mclk(mclk), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso_o(miso_o),
      .miso_oe(miso_oe), .serial_out_pulldown_enable(serial_out_pulldown_enable), .irq(irq),
      .tx_buf_data(tx_buf_data), .tx_buf_valid(tx_buf_valid), .tx_buf_ready(tx_buf_ready),
      .rx_buf_data(rx_buf_data), .rx_buf_valid(rx_buf_valid), .rx_buf_pop(rx_buf_pop),
      .cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .cmd_busy(cmd_busy),
      .rf_ee_req(rf_ee_req), .rf_ee_grant(rf_ee_grant));
   spi_master_model u_spi_master_model (
      .mclk(mclk), .ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso_pin));
   // Far-side models: receive buffer source, transmit sink, command monitor, idle miso.
   always @(posedge mclk) begin
      idle_q <= ~idle_q;
      if (cmd_strobe === 1'b1) begin
         strobes <= strobes + 1;
         last_code <= cmd_code;
      end
      if (rx_buf_pop === 1'b1) begin
         rx_idx <= rx_idx + 4'h1;
      end
      if (tx_buf_valid === 1'b1 && tx_buf_ready) begin
         txq.push_back(tx_buf_data);
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic xv(input int n, input logic [79:0] v, input int lastb);
      logic [7:0] r;
      u_spi_master_model.start();
      for (int k = 0; k < n; k++) begin
         u_spi_master_model.xfer(v[8*(n-1-k) +: 8], (k == n - 1) ? lastb : 8, r);
         rxb[k] = r;
      end
      u_spi_master_model.stop();
   endtask
   function automatic logic [31:0] rd(input int from, input int n);
      logic [31:0] v;
      v = 32'h0;
      for (int k = 0; k < n; k++) begin
         v = {v[23:0], rxb[from + k]};
      end
      return v;
   endfunction
   task automatic t_regs();
      xv(5, 80'h00_01_a5_5a_c3, 8);
      tick(4);
      check("pulldown", serial_out_pulldown_enable, 32'h1);
      xv(4, 80'h21_00_00_00, 8);
      check("reg1..3", rd(1, 3), 32'ha5_5ac3);
   endtask
   task automatic t_partial();
      xv(3, 80'h04_11_ff, 4);
      xv(3, 80'h24_00_00, 8);
      check("partial", rd(1, 2), {16'h0, 8'h11, spi_port_pkg::REG_RESET});
   endtask
   task automatic t_ro();
      logic [7:0] v;
      xv(2, 80'h34_00, 8);
      v = rxb[1];
      xv(2, {64'h0, 8'h14, ~v}, 8);
      xv(2, 80'h1e_77, 8);
      xv(2, 80'h34_00, 8);
      check("ro reg", rxb[1], v);
      xv(2, 80'h3e_00, 8);
      check("unmapped", rxb[1], 32'h0);
   endtask
   task automatic ee_wr(input logic [6:0] blk, input logic [31:0] d, input bit wait_irq);
      int n;
      xv(6, {32'h0, 8'h40, blk, 1'b1, d}, 8);
      if (wait_irq) begin
         for (n = 4; n < P + 40 && irq !== 1'b1; n++) begin
            @(posedge mclk);
         end
         check("irq delay", 32'(n >= P && n <= P + 12), 32'h1);
      end
   endtask
   task automatic ee_rd(input logic [6:0] blk, input logic [63:0] exp);
      u_spi_master_model.half = 10;
      xv(10, {8'h7f, blk, 1'b0, 64'h0}, 8);
      u_spi_master_model.half = 4;
      check("ee block", rd(2, 4), exp[63:32]);
      check("ee next", rd(6, 4), exp[31:0]);
   endtask
   task automatic t_ee();
      ee_wr(7'h05, 32'hdead_beef, 1'b1);
      ee_wr(7'h06, 32'h0123_4567, 1'b1);
      ee_rd(7'h05, 64'hdead_beef_0123_4567);
      ee_rd(7'h78, 64'h0);
      rf_ee_req <= 1'b1;
      tick(6);
      check("rf grant", rf_ee_grant, 32'h1);
      ee_wr(7'h05, 32'h0, 1'b0);
      rf_ee_req <= 1'b0;
      tick(P + 20);
      ee_rd(7'h05, 64'hdead_beef_0123_4567);
   endtask
   task automatic t_buf_ld();
      logic [7:0] r;
      u_spi_master_model.start();
      u_spi_master_model.xfer(8'h80, 8, r);
      for (int k = 0; k < spi_port_pkg::BUF_DEPTH + 2; k++) begin
         u_spi_master_model.xfer(8'(k), 8, r);
      end
      u_spi_master_model.stop();
      check("tx stalled", txq.size(), 32'h0);
      tx_buf_ready <= 1'b1;
      tick(40);
      check("tx count", txq.size(), 32'(spi_port_pkg::BUF_DEPTH));
      for (int k = 0; k < spi_port_pkg::BUF_DEPTH; k++) begin
         check("tx byte", txq[k], 32'(k));
      end
   endtask
   task automatic t_buf_rd();
      xv(4, 80'ha0_00_00_00, 4);
      check("rx bytes", rd(1, 2), 32'h4041);
      xv(2, 80'ha0_00, 8);
      check("rx after cut", rxb[1], 32'h43);
   endtask
   task automatic t_cmd();
      int s;
      for (int c = 0; c < 2; c++) begin
         cmd_busy <= c[0];
         s = strobes;
         xv(2, {64'h0, 2'b11, (c[0] ? 6'h15 : 6'h2a), 8'h00}, 8);
         check("cmd answer", rxb[1], c[0] ? 8'h02 : 8'h01);
         check("cmd strobes", strobes - s, 32'(1 - c));
      end
      check("cmd code", last_code, 32'h2a);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      for (int k = 0; k < 8; k++) begin
         rx_mem[k] = 8'h40 + 8'(k);
      end
      tick(20);
      rst <= 1'b0;
      tick(5);
      t_regs();
      t_partial();
      t_ro();
      t_ee();
      t_buf_ld();
      t_buf_rd();
      t_cmd();
      report_and_stop();
   end
   initial begin
      tick(60000);
      fail_count++;
      $display("[ERR] watchdog expected done seen hang");
      report_and_stop();
   end
endmodule
bind nfc_host_port nfc_host_port_checker #(.EE_PROG_CYCLES(EE_PROG_CYCLES)) u_chk (
   .mclk(mclk), .rst(rst), .ss_n(ss_n), .sclk(sclk), .miso_o(miso_o), .miso_oe(miso_oe),
   .irq(irq), .rx_buf_valid(rx_buf_valid), .rx_buf_pop(rx_buf_pop), .cmd_strobe(cmd_strobe),
   .cmd_busy(cmd_busy), .rf_ee_req(rf_ee_req), .rf_ee_grant(rf_ee_grant));
